// >>> rtl/lp_sdram_command_timing.sv
/*
  Device-side command decode, burst engine, byte masking and read output
  timing of a low-power single-data-rate SDRAM with a small backing store.
  Assumes the controller runs on the same clock and keeps its own spacing
  between commands; no reset pin exists on the part, rst_n is the model's.
*/
`timescale 1ns/1ps
// What this block does
// - Read or write accepted every clock
// - Clock enable low suspends one clock later
// - Clock enable high resumes one clock later
// - Write byte mask applies with zero latency
// - Read byte mask floats data two clocks later
// - First write data taken with command
// - Precharge truncated read drains latency clocks
module lp_sdram_command_timing
  import lp_sdram_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [BANK_W-1:0] bank,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [LANES-1:0]  dqm,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic [LANES-1:0]       dq_oe
);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  cmd_t              cmd;
  burst_state_t      state;
  burst_state_t      next_state;
  logic              cke_q;
  logic              enabled;
  logic [1:0]        latency;
  logic [2:0]        burst_code;
  logic [COL_W-1:0]  burst_mask;
  logic [COL_W-1:0]  b_col;
  logic [COL_W-1:0]  b_left;
  logic [BANK_W-1:0] b_bank;
  logic [COL_W-1:0]  iss_col;
  logic [BANK_W-1:0] iss_bank;
  logic [COL_W-1:0]  next_col;
  logic [COL_W-1:0]  next_left;
  logic              iss_rd;
  logic              iss_wr;
  logic              stop_hit;
  logic              pre_hit;
  logic [MEM_IDX_W-1:0] mem_idx;
  logic [MEM_IDX_W-1:0] idx_q;
  // Nets, because each byte lane drives its own slice
  wire logic [DATA_W-1:0] rd_word;
  wire logic [DATA_W-1:0] peek_word;
  logic [LANES-1:0]  dqm_d1;
  logic [LANES-1:0]  dqm_d2;
  logic              first_valid;
  logic              out_valid;
  logic [DATA_W-1:0] out_data;
  logic              dq_valid;

  // ----------------------------------------------------------------
  // Clock enable and command decode
  // ----------------------------------------------------------------
  // A low level seen on one edge freezes the next edge, and a high level
  // frees it again one edge later.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke;
    end
  end

  assign enabled  = cke_q;
  assign cmd      = cs_n ? CMD_NOP : cmd_t'({ras_n, cas_n, we_n});
  assign pre_hit  = (cmd == CMD_PRE) && (addr[ALL_BANKS] || (bank == b_bank));
  assign stop_hit = (cmd == CMD_STOP) || pre_hit;

  a_suspend_entry: assert property (
    !cke |-> ##2 ($stable(b_col) && $stable(state) && $stable(dq_out) && $stable(dq_oe)))
    else $error("edge one clock after clock enable low was not frozen");

  sequence s_wake_read;
    !cke ##1 cke ##1 (cmd == CMD_READ);
  endsequence

  a_resume_read: assert property (s_wake_read |=> first_valid)
    else $error("read one clock after clock enable high was not taken");

  // ----------------------------------------------------------------
  // Mode word
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latency    <= LAT_RESET;
      burst_code <= BL_RESET;
    end else if (enabled && (cmd == CMD_MODE)) begin
      burst_code <= addr[MODE_BL_LSB +: MODE_BL_W];
      // Reserved latency codes leave the previous setting in force
      if ((addr[MODE_LAT_LSB +: MODE_LAT_W] != 3'h0)
          && (addr[MODE_LAT_LSB +: MODE_LAT_W] <= {1'b0, LAT_3})) begin
        latency <= addr[MODE_LAT_LSB +: 2];
      end
    end
  end

  always_comb begin
    case (burst_code)
      BL_1:    burst_mask = MASK_1;
      BL_2:    burst_mask = MASK_2;
      BL_4:    burst_mask = MASK_4;
      BL_8:    burst_mask = MASK_8;
      BL_PAGE: burst_mask = MASK_PAGE;
      default: burst_mask = MASK_1;
    endcase
  end

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  // A new read or write always wins over a running burst, so accesses can
  // follow each other on every clock.
  always_comb begin
    iss_rd     = 1'b0;
    iss_wr     = 1'b0;
    iss_col    = b_col;
    iss_bank   = b_bank;
    next_state = state;
    next_left  = b_left;
    if (enabled) begin
      if ((cmd == CMD_READ) || (cmd == CMD_WRITE)) begin
        iss_rd     = (cmd == CMD_READ);
        iss_wr     = (cmd == CMD_WRITE);
        iss_col    = addr[COL_W-1:0];
        iss_bank   = bank;
        next_left  = burst_mask;
        if (burst_mask == MASK_1) begin
          next_state = BURST_IDLE;
        end else if (cmd == CMD_READ) begin
          next_state = BURST_READ;
        end else begin
          next_state = BURST_WRITE;
        end
      end else if (stop_hit) begin
        next_state = BURST_IDLE;
      end else if (state != BURST_IDLE) begin
        iss_rd    = (state == BURST_READ);
        iss_wr    = (state == BURST_WRITE);
        next_left = b_left - COL_ONE;
        // A full page burst wraps until stopped
        if ((burst_code != BL_PAGE) && (b_left == COL_ONE)) begin
          next_state = BURST_IDLE;
        end
      end
    end
  end

  assign next_col = (iss_col & ~burst_mask) | ((iss_col + COL_ONE) & burst_mask);
  assign mem_idx  = {iss_bank, iss_col[MEM_COL_W-1:0]};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state  <= BURST_IDLE;
      b_left <= '0;
    end else begin
      state  <= next_state;
      b_left <= next_left;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      b_col  <= '0;
      b_bank <= '0;
    end else if (iss_rd || iss_wr) begin
      b_col  <= next_col;
      b_bank <= iss_bank;
    end
  end

  sequence s_two_reads;
    (enabled && (cmd == CMD_READ)) ##1 (enabled && (cmd == CMD_READ));
  endsequence

  a_read_rate: assert property (s_two_reads |=> (first_valid && $past(first_valid)))
    else $error("back to back reads were not both taken");

  // ----------------------------------------------------------------
  // Backing store, one array per byte lane
  // ----------------------------------------------------------------
  // Data is written on the edge of the command itself, and a mask bit seen
  // on that same edge drops the lane.
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] lane_mem [MEM_WORDS];

    always_ff @(posedge clock) begin
      if (iss_wr && !dqm[g]) begin
        lane_mem[mem_idx] <= dq_in[g*LANE_W +: LANE_W];
      end
    end

    assign rd_word[g*LANE_W +: LANE_W]   = lane_mem[mem_idx];
    assign peek_word[g*LANE_W +: LANE_W] = lane_mem[idx_q];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= '0;
    end else begin
      idx_q <= mem_idx;
    end
  end

  a_write_mask: assert property (
    (iss_wr && (dqm == 2'h3)) |=> (peek_word == $past(rd_word)))
    else $error("masked write data altered the store");

  a_write_first: assert property (
    (iss_wr && (dqm == 2'h0)) |=> (peek_word == $past(dq_in)))
    else $error("write data on the command edge was not stored");

  // ----------------------------------------------------------------
  // Read output path
  // ----------------------------------------------------------------
  read_latency_pipe u_pipe (
    .clock       (clock),
    .rst_n       (rst_n),
    .advance     (enabled),
    .flush       (iss_wr),
    .latency     (latency),
    .in_valid    (iss_rd),
    .in_data     (rd_word),
    .first_valid (first_valid),
    .out_valid   (out_valid),
    .out_data    (out_data)
  );

  // The mask is delayed on the internal clock, so suspension stretches it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dqm_d1 <= '0;
      dqm_d2 <= '0;
    end else if (enabled) begin
      dqm_d1 <= dqm;
      dqm_d2 <= dqm_d1;
    end
  end

  // A registered write floats the bus whatever the mask says, which keeps
  // the controller's write data clear of stale read data.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dq_valid <= 1'b0;
      dq_out   <= '0;
      dq_oe    <= '0;
    end else if (enabled) begin
      dq_valid <= out_valid && !iss_wr;
      dq_out   <= out_data;
      dq_oe    <= {LANES{out_valid && !iss_wr}} & ~dqm_d2;
    end
  end

  a_dqm_float: assert property (
    (enabled && dqm[0]) ##1 enabled ##1 enabled |=> !dq_oe[0])
    else $error("lane zero still driven two clocks after its mask");

  sequence s_pre_cut;
    (enabled && pre_hit && (state == BURST_READ) && (latency == LAT_3))
      ##1 (enabled && (cmd != CMD_READ) && (cmd != CMD_WRITE))[*3];
  endsequence

  a_pre_drain: assert property (s_pre_cut |-> (dq_valid ##1 !dq_valid))
    else $error("read data after precharge did not drain over three clocks");

endmodule : lp_sdram_command_timing

// >>> rtl/lp_sdram_pkg.sv
/*
  Shared constants and types for the low-power SDRAM command and data path
  seen from inside the memory device.
  Assumes a controller on the same clock that drives the command pins.
*/
package lp_sdram_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int BANK_W    = 2;
  localparam int ADDR_W    = 13;
  localparam int COL_W     = 9;
  localparam int DATA_W    = 16;
  localparam int LANES     = 2;
  localparam int LANE_W    = 8;
  // Only the low column bits address the small backing store
  localparam int MEM_COL_W = 4;
  localparam int MEM_IDX_W = BANK_W + MEM_COL_W;
  localparam int MEM_WORDS = 1 << MEM_IDX_W;
  localparam int PIPE_D    = 3;

  // ----------------------------------------------------------------
  // Mode word layout and address bits
  // ----------------------------------------------------------------
  localparam int MODE_BL_LSB  = 0;
  localparam int MODE_BL_W    = 3;
  localparam int MODE_LAT_LSB = 4;
  localparam int MODE_LAT_W   = 3;
  localparam int ALL_BANKS    = 10;

  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  localparam logic [COL_W-1:0] MASK_1    = 9'h000;
  localparam logic [COL_W-1:0] MASK_2    = 9'h001;
  localparam logic [COL_W-1:0] MASK_4    = 9'h003;
  localparam logic [COL_W-1:0] MASK_8    = 9'h007;
  localparam logic [COL_W-1:0] MASK_PAGE = 9'h1ff;
  localparam logic [COL_W-1:0] COL_ONE   = 9'h001;

  // ----------------------------------------------------------------
  // Latencies and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] LAT_1     = 2'h1;
  localparam logic [1:0] LAT_2     = 2'h2;
  localparam logic [1:0] LAT_3     = 2'h3;
  localparam logic [1:0] LAT_RESET = 2'h3;
  localparam logic [2:0] BL_RESET  = 3'h0;
  localparam int DQZ_CLK  = 2;
  localparam int DQM_W_CLK = 0;
  localparam int CKE_CLK  = 1;

  // ----------------------------------------------------------------
  // Commands {ras_n, cas_n, we_n} and burst states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_MODE  = 3'b000,
    CMD_REF   = 3'b001,
    CMD_PRE   = 3'b010,
    CMD_ACT   = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_READ  = 3'b101,
    CMD_STOP  = 3'b110,
    CMD_NOP   = 3'b111
  } cmd_t;

  typedef enum logic [1:0] {
    BURST_IDLE  = 2'b00,
    BURST_READ  = 2'b01,
    BURST_WRITE = 2'b10
  } burst_state_t;

endpackage : lp_sdram_pkg

// >>> rtl/read_latency_pipe.sv
/*
  Read data delay line with a selectable tap for the read latency setting.
  Assumes latency is 1, 2 or 3 and that advance follows the internal clock.
*/
`timescale 1ns/1ps
module read_latency_pipe
  import lp_sdram_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              advance,
  input  wire logic              flush,
  input  wire logic [1:0]        latency,
  input  wire logic              in_valid,
  input  wire logic [DATA_W-1:0] in_data,
  output logic                   first_valid,
  output logic                   out_valid,
  output logic [DATA_W-1:0]      out_data
);

  logic              stage_v [PIPE_D];
  logic [DATA_W-1:0] stage_d [PIPE_D];

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  for (genvar g = 0; g < PIPE_D; g++) begin : g_stage
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        stage_v[g] <= 1'b0;
        stage_d[g] <= '0;
      end else if (flush) begin
        stage_v[g] <= 1'b0;
      end else if (advance) begin
        stage_v[g] <= (g == 0) ? in_valid : stage_v[(g == 0) ? 0 : g - 1];
        stage_d[g] <= (g == 0) ? in_data : stage_d[(g == 0) ? 0 : g - 1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Tap select
  // ----------------------------------------------------------------
  always_comb begin
    case (latency)
      LAT_1: begin
        out_valid = stage_v[0];
        out_data  = stage_d[0];
      end
      LAT_2: begin
        out_valid = stage_v[1];
        out_data  = stage_d[1];
      end
      default: begin
        out_valid = stage_v[2];
        out_data  = stage_d[2];
      end
    endcase
  end

  assign first_valid = stage_v[0];

endmodule : read_latency_pipe

// >>> testbench/sdram_ctrl.sv
/*
  Memory controller model driving the command, mask and write data pins.
  Assumes one caller thread issues its tasks one after another.
*/
`timescale 1ns/1ps
module sdram_ctrl
  import lp_sdram_pkg::*;
(
  input  wire logic              clock,
  output logic                   cke,
  output logic                   cs_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic [BANK_W-1:0]      bank,
  output logic [ADDR_W-1:0]      addr,
  output logic [LANES-1:0]       dqm,
  output logic [DATA_W-1:0]      dq_in
);
  localparam int POWER_UP_CLOCKS = 4000;
  int edges = 0;

  always @(posedge clock) begin
    edges <= edges + 1;
  end

  initial begin
    cke   = 1'b1;
    cs_n  = 1'b1;
    ras_n = 1'b1;
    cas_n = 1'b1;
    we_n  = 1'b1;
    bank  = '0;
    addr  = '0;
    dqm   = '0;
    dq_in = '0;
  end

  // ----------------------------------------------------------------
  // Command issue; at_edge is the edge count at which it is sampled
  // ----------------------------------------------------------------
  task automatic send(input cmd_t cmd, input logic [BANK_W-1:0] bk,
                      input logic [ADDR_W-1:0] ad, input logic [LANES-1:0] dm,
                      input logic [DATA_W-1:0] d, input logic ce, output int at_edge);
    int gap;
    // One clock is 50 ns, so one deselect edge covers every minimum gap
    gap = 0;
    if (cmd == CMD_MODE || cmd == CMD_REF) gap = 1;
    if (cmd == CMD_ACT) gap = 1;
    @(posedge clock);
    at_edge = edges + 2;
    cke <= ce;
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= cmd;
    bank <= bk;
    addr <= ad;
    dqm <= dm;
    dq_in <= d;
    repeat (gap) begin
      @(posedge clock);
      cs_n <= 1'b1;
      dq_in <= ~d;
    end
  endtask : send

  task automatic power_up();
    int e;
    repeat (POWER_UP_CLOCKS) @(posedge clock);
    send(CMD_REF, '0, '0, '0, '0, 1'b1, e);
    send(CMD_REF, '0, '0, '0, '0, 1'b1, e);
  endtask : power_up
endmodule : sdram_ctrl

// >>> testbench/lp_sdram_command_timing_tb.sv
/*
  Self-checking bench for the SDRAM command timing block.
  Assumes the controller model drives every pin and reports command edges.
*/
`timescale 1ns/1ps
module lp_sdram_command_timing_tb
  import lp_sdram_pkg::*;
;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              cke, cs_n, ras_n, cas_n, we_n;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0]  dqm, dq_oe;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic [DATA_W-1:0] mem [MEM_WORDS];
  logic [DATA_W-1:0] exp_dq [16];
  logic [LANES-1:0]  exp_oe [16];
  logic [LANES-1:0]  exp_mk [16];
  logic [2:0]        codes [5] = '{BL_1, BL_2, BL_4, BL_8, BL_PAGE};
  logic [COL_W-1:0]  bmask = MASK_1;
  int                lat = 3;
  int                seed = 32'ha4c5;
  int                mismatches = 0;
  int                num_checks = 0;

  always #25 clock = ~clock;

  sdram_ctrl sdram_ctrl_inst (.clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank(bank), .addr(addr), .dqm(dqm), .dq_in(dq_in));
  lp_sdram_command_timing lp_sdram_command_timing_inst (.clock(clock), .rst_n(rst_n),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank(bank),
    .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

  // ----------------------------------------------------------------
  // Expected output ring, one slot per edge, checked after each edge
  // ----------------------------------------------------------------
  always @(posedge clock) begin : watch
    int s;
    logic [LANES-1:0] on;
    #1;
    s = sdram_ctrl_inst.edges % 16;
    on = exp_oe[s] & ~exp_mk[s];
    num_checks++;
    if ((dq_oe !== on) || (on[0] && dq_out[7:0] !== exp_dq[s][7:0]) ||
        (on[1] && dq_out[15:8] !== exp_dq[s][15:8])) begin
      $display("unexpected dq at %0t: oe %h/%h data %h/%h", $time, dq_oe, on, dq_out, exp_dq[s]);
      mismatches++;
    end
    exp_oe[s] = 2'h0;
    exp_mk[s] = 2'h0;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic clear(input int from);
    for (int s = from; s < from + 10; s++) exp_oe[s % 16] = 2'h0;
  endtask : clear

  task automatic op(input cmd_t cmd, input logic [BANK_W-1:0] bk, input logic [ADDR_W-1:0] ad,
                    input logic [LANES-1:0] dm, input logic [DATA_W-1:0] d);
    int e;
    logic [COL_W-1:0] col;
    sdram_ctrl_inst.send(cmd, bk, ad, dm, d, 1'b1, e);
    exp_mk[(e + 2) % 16] |= dm;
    // A new access, a stop or a precharge ends the running read burst
    if (cmd == CMD_READ || cmd == CMD_STOP || cmd == CMD_PRE) clear(e + lat);
    if (cmd == CMD_WRITE) clear(e);
    if (cmd == CMD_READ) begin
      for (int i = 0; i <= int'(bmask) && i < 9; i++) begin
        col = (ad[COL_W-1:0] & ~bmask) | ((ad[COL_W-1:0] + COL_W'(i)) & bmask);
        exp_dq[(e + lat + i) % 16] = mem[{bk, col[MEM_COL_W-1:0]}];
        exp_oe[(e + lat + i) % 16] = 2'h3;
      end
    end
  endtask : op

  task automatic idle(input int n);
    logic [DATA_W-1:0] r;
    repeat (n) begin
      r = DATA_W'($random(seed));
      op(CMD_NOP, r[1:0], r[12:0], r[3:2], r);
    end
  endtask : idle

  task automatic rd(input logic [BANK_W-1:0] bk, input logic [COL_W-1:0] c);
    logic [DATA_W-1:0] r;
    r = DATA_W'($random(seed));
    op(CMD_READ, bk, {4'h0, c}, r[1:0], r);
  endtask : rd

  task automatic wr_burst(input logic [BANK_W-1:0] bk, input logic [COL_W-1:0] c,
                          input int n, input logic rm);
    logic [COL_W-1:0] col;
    logic [DATA_W-1:0] d;
    logic [LANES-1:0] dm;
    for (int i = 0; i < n; i++) begin
      col = (c & ~bmask) | ((c + COL_W'(i)) & bmask);
      d = DATA_W'($random(seed));
      dm = LANES'($random(seed)) & {LANES{rm}};
      if (!dm[0]) mem[{bk, col[MEM_COL_W-1:0]}][7:0] = d[7:0];
      if (!dm[1]) mem[{bk, col[MEM_COL_W-1:0]}][15:8] = d[15:8];
      op((i == 0) ? CMD_WRITE : CMD_NOP, bk, {4'h0, c}, dm, d);
    end
  endtask : wr_burst

  task automatic set_mode(input logic [2:0] lc, input logic [2:0] bl);
    op(CMD_MODE, 2'h0, {6'h00, lc, 1'b0, bl}, 2'h0, 16'h0);
    if (lc inside {[3'h1:3'h3]}) lat = int'(lc);
    case (bl)
      BL_2: bmask = MASK_2;
      BL_4: bmask = MASK_4;
      BL_8: bmask = MASK_8;
      BL_PAGE: bmask = MASK_PAGE;
      default: bmask = MASK_1;
    endcase
  endtask : set_mode

  // Suspend one edge; the write on the frozen edge must be ignored
  task automatic freeze();
    int e;
    sdram_ctrl_inst.send(CMD_NOP, 2'h0, 13'h0, 2'h0, 16'h0, 1'b0, e);
    for (int s = e + 10; s > e; s--) begin
      exp_oe[s % 16] = exp_oe[(s - 1) % 16];
      exp_mk[s % 16] = exp_mk[(s - 1) % 16];
      exp_dq[s % 16] = exp_dq[(s - 1) % 16];
    end
    sdram_ctrl_inst.send(CMD_WRITE, 2'h1, 13'h0005, 2'h0, ~mem[21], 1'b1, e);
  endtask : freeze

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [COL_W-1:0] c;
    logic [BANK_W-1:0] b;
    int n;
    for (int i = 0; i < 16; i++) begin
      exp_oe[i] = 2'h0;
      exp_mk[i] = 2'h0;
      exp_dq[i] = 16'h0;
    end
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    sdram_ctrl_inst.power_up();
    for (int i = 0; i < 4; i++) op(CMD_ACT, BANK_W'(i), 13'h0011, 2'h0, 16'h0);
    set_mode(3'h3, BL_8);
    for (int i = 0; i < 8; i++) wr_burst(BANK_W'(i / 2), COL_W'((i % 2) * 8), 8, 1'b0);
    for (int l = 1; l <= 3; l++) begin
      for (int k = 0; k < 5; k++) begin
        set_mode(3'(l), codes[k]);
        b = BANK_W'($random(seed));
        c = COL_W'($random(seed));
        n = (codes[k] == BL_PAGE) ? 6 : int'(bmask) + 1;
        wr_burst(b, c, n, 1'b1);
        if (codes[k] == BL_PAGE) op(CMD_STOP, b, 13'h0, 2'h0, 16'h0);
        rd(b, c);
        if (codes[k] == BL_PAGE) begin
          idle(2);
          op(CMD_PRE, b, 13'h0, 2'h0, 16'h0);
          op(CMD_ACT, b, 13'h0011, 2'h0, 16'h0);
        end
        idle(n + 4);
      end
    end
    set_mode(3'h2, BL_4);
    for (int i = 0; i < 12; i++) rd(BANK_W'($random(seed)), COL_W'($random(seed)));
    op(CMD_STOP, 2'h0, 13'h0, 2'h0, 16'h0);
    idle(6);
    set_mode(3'h4, BL_4);
    rd(2'h3, 9'h1f3);
    idle(1);
    // All-banks precharge with other bank pins must still cut the burst
    op(CMD_PRE, 2'h0, 13'h0400, 2'h0, 16'h0);
    idle(6);
    rd(2'h1, 9'h004);
    freeze();
    rd(2'h1, 9'h005);
    idle(8);
    final_report();
  end

  initial begin : watchdog
    repeat (20000) @(posedge clock);
    mismatches++;
    final_report();
  end
endmodule : lp_sdram_command_timing_tb
